// file: pkg/lin_mode_pkg.sv
// constants, field layouts and state codes of the lin transceiver mode controller
//
// Summary of operation
// - exactly four states: off, wake, listen, active
// - listen and active only in normal power
// - low power keeps wake-capable state for wake-up
// - safety outputs force off unless shutdown disabled
// - off when wake disabled and mode 00, in normal or low power
// - off disables everything, receive pin held high
// - wake-capable whenever mode nonzero or wake enabled
// - wake-capable: only low-power receiver, receive pin high
// - wake event: long bus low then rising edge
// - wake low time between 30 and 150 us
// - wake to listen on mode 01, or on mode 1x when active is not entered
// - listen: normal receiver only, never transmits
// - to active on mode 1x with tx high
// - active: transmitter and normal receiver on
// - reduced slope in active when slope select is 10
// - thermal, timeout or short: back to listen
// - after timeout or short, transmitter re-enabled by tx rising edge or by going off
// - tx dominant timeout between 5.0 and 8.6 ms
// - short declared after 20 to 30 us
package lin_mode_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_PERIOD_NS = 50;  // 20 mhz bus clock
  localparam int unsigned WAKE_DOM_TIME_US = 80;  // nominal bus-low time for a wake
  localparam int unsigned WAKE_DOM_CYCLES =
    (WAKE_DOM_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TX_DOM_TIMEOUT_US = 7200;  // nominal tx dominant timeout
  localparam int unsigned TX_DOM_TIMEOUT_CYCLES =
    (TX_DOM_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned SHORT_DETECT_TIME_US = 25;  // nominal short detection time
  localparam int unsigned SHORT_DETECT_CYCLES =
    (SHORT_DETECT_TIME_US * 1000) / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;  // mode, wake enable, failsafe, slope
  localparam logic [7:0] ADDR_STATUS = 8'h04;  // live state, read only
  localparam logic [7:0] ADDR_FLAGS = 8'h08;  // sticky events, write one to clear

  // control field positions
  localparam int unsigned CTRL_MODE_LSB = 0;  // two-bit mode setting
  localparam int unsigned CTRL_WAKE_EN_BIT = 2;  // wake capability enable
  localparam int unsigned CTRL_FS_DIS_BIT = 3;  // failsafe_shutdown_disable
  localparam int unsigned CTRL_SLOPE_LSB = 4;  // two-bit slope_select

  // status field positions
  localparam int unsigned STAT_STATE_LSB = 0;  // one-hot state, four bits
  localparam int unsigned STAT_TX_EN_BIT = 4;  // transmitter enabled
  localparam int unsigned STAT_TX_BLOCK_BIT = 5;  // waiting for tx rising edge
  localparam int unsigned STAT_FORCED_BIT = 6;  // safety outputs force off

  // flag positions
  localparam int unsigned FLAG_WAKE_BIT = 0;  // qualified bus wake-up
  localparam int unsigned FLAG_DOM_TO_BIT = 1;  // tx dominant timeout
  localparam int unsigned FLAG_SHORT_BIT = 2;  // bus short circuit
  localparam int unsigned FLAG_THERMAL_BIT = 3;  // thermal fallback

  // reset values and encodings
  localparam logic [1:0] MODE_RESET = 2'h0;  // off
  localparam logic [1:0] MODE_OFF = 2'h0;  // mode setting 00
  localparam logic [1:0] MODE_LISTEN = 2'h1;  // mode setting 01
  localparam logic [1:0] SLOPE_RESET = 2'h0;  // normal slope
  localparam logic [1:0] SLOPE_REDUCED = 2'h2;  // low emission slope
  localparam logic [3:0] FLAGS_RESET = 4'h0;  // no events

  // transceiver states, one-hot
  typedef enum logic [3:0] {
    ST_OFF = 4'h1,
    ST_WAKE = 4'h2,
    ST_LISTEN = 4'h4,
    ST_ACTIVE = 4'h8
  } lin_state_e;

endpackage

// file: core/hold_timer.sv
// counter that reports a condition held for a given number of cycles
`timescale 1ns/1ns
module hold_timer #(
  parameter int unsigned LIMIT = 2  // cycles the condition must hold
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // condition and result
  input wire logic run,
  output logic done
);

  localparam int unsigned W = $clog2(LIMIT + 1);
  localparam logic [W-1:0] LIM = W'(LIMIT);

  typedef struct packed {
    logic [W-1:0] cnt;  // cycles held so far
  } hold_s;

  hold_s r;
  hold_s n;

  ////////////////////////////////////////////////////////////////////////////////
  // count while held, saturate at the limit, restart when the condition drops
  always_comb begin
    n = r;
    if (!run) begin
      n.cnt = '0;
    end else if (r.cnt != LIM) begin
      n.cnt = r.cnt + W'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // level while the hold time has been reached
  assign done = run && (r.cnt == LIM);

endmodule

// file: core/rise_detect.sv
// one-cycle pulse on a rising edge of a synchronous input
`timescale 1ns/1ns
module rise_detect (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // level in, pulse out
  input wire logic d,
  output logic rise
);

  typedef struct packed {
    logic prev;  // level seen last cycle
  } edge_s;

  edge_s r;
  edge_s n;

  ////////////////////////////////////////////////////////////////////////////////
  // remember the previous level; resets high so a line idling high gives no edge
  always_comb begin
    n = r;
    n.prev = d;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '{prev: 1'b1};
    end else begin
      r <= n;
    end
  end

  assign rise = d && !r.prev;

endmodule

// file: core/lin_transceiver_mode_control.sv
// lin transceiver mode controller with ahb-lite register access
//
// Our own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ns
module lin_transceiver_mode_control #(
  // tx dominant timeout in cycles, shorten for simulation
  parameter int unsigned DOM_TIMEOUT_CYCLES = lin_mode_pkg::TX_DOM_TIMEOUT_CYCLES
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // device power and safety state
  input wire logic device_normal,
  input wire logic reset_output,
  input wire logic safety_output_0,
  input wire logic limp_home_output,
  input wire logic thermal_shutdown,
  // microcontroller side pins
  input wire logic tx_in_pin,
  output logic rx_out_pin,
  // analog front end
  input wire logic bus_rx_level,
  input wire logic lp_rx_level,
  input wire logic bus_short_fault,
  output logic tx_driver_en,
  output logic bus_tx_level,
  output logic normal_rx_en,
  output logic lp_rx_en,
  output logic slope_reduced,
  // events
  output logic wake_event
);

  ////////////////////////////////////////////////////////////////////////////////
  // state of the block

  typedef struct packed {
    lin_mode_pkg::lin_state_e state;  // transceiver state
    logic [1:0] mode;  // software mode setting
    logic wake_en;  // wake capability enable
    logic fs_dis;  // failsafe_shutdown_disable
    logic [1:0] slope;  // slope_select
    logic [3:0] flags;  // sticky event flags
    logic armed;  // bus low long enough, waiting for release
    logic tx_block;  // transmitter held off until tx rising edge
    logic wr_pend;  // write data phase pending
    logic [7:0] waddr;  // address of pending write
    logic [31:0] rdata;  // read data for the data phase
    logic rx_out;  // level on rx_out_pin
    logic tx_en;  // transmitter enable
    logic tx_lvl;  // level sent to the bus driver
    logic nrx_en;  // normal receiver enable
    logic lprx_en;  // low-power receiver enable
    logic slope_lo;  // reduced slope active
    logic wake_pulse;  // wake event pulse
  } ctl_s;

  localparam ctl_s CTL_RESET = '{
    state: lin_mode_pkg::ST_OFF,
    mode: lin_mode_pkg::MODE_RESET,
    wake_en: 1'b0,
    fs_dis: 1'b0,
    slope: lin_mode_pkg::SLOPE_RESET,
    flags: lin_mode_pkg::FLAGS_RESET,
    armed: 1'b0,
    tx_block: 1'b0,
    wr_pend: 1'b0,
    waddr: 8'h00,
    rdata: 32'h0000_0000,
    rx_out: 1'b1,
    tx_en: 1'b0,
    tx_lvl: 1'b1,
    nrx_en: 1'b0,
    lprx_en: 1'b0,
    slope_lo: 1'b0,
    wake_pulse: 1'b0
  };

  ctl_s r;  // registered state
  ctl_s n;  // next state

  ////////////////////////////////////////////////////////////////////////////////
  // timers and edge detectors

  logic wake_low_done;  // bus held low for the wake time
  logic dom_to_done;  // tx held dominant too long
  logic short_done;  // short condition held long enough
  logic lp_rise;  // bus released on low-power receiver
  logic tx_rise;  // rising edge on tx_in_pin

  // bus low qualification for a wake-up, only while wake-capable
  hold_timer #(
    .LIMIT(lin_mode_pkg::WAKE_DOM_CYCLES)
  ) u_wake_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .run((r.state == lin_mode_pkg::ST_WAKE) && !lp_rx_level),
    .done(wake_low_done)
  );

  // transmit dominant timeout, only while active
  hold_timer #(
    .LIMIT(DOM_TIMEOUT_CYCLES)
  ) u_dom_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .run((r.state == lin_mode_pkg::ST_ACTIVE) && !tx_in_pin),
    .done(dom_to_done)
  );

  // short circuit filter, only while active
  hold_timer #(
    .LIMIT(lin_mode_pkg::SHORT_DETECT_CYCLES)
  ) u_short_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .run((r.state == lin_mode_pkg::ST_ACTIVE) && bus_short_fault),
    .done(short_done)
  );

  // release of the bus after a long low
  rise_detect u_lp_rise (
    .hclk(hclk),
    .hresetn(hresetn),
    .d(lp_rx_level),
    .rise(lp_rise)
  );

  // host edge that re-arms the transmitter
  rise_detect u_tx_rise (
    .hclk(hclk),
    .hresetn(hresetn),
    .d(tx_in_pin),
    .rise(tx_rise)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // decoded conditions

  logic forced_off;  // safety outputs hold the transceiver off
  logic want_wake;  // transceiver must be at least wake-capable
  logic go_active;  // conditions to enter active
  logic go_listen;  // conditions to sit in listen-only
  logic fault_hit;  // fallback cause while active
  logic addr_valid;  // ahb address phase taken
  logic wake_hit;  // qualified wake-up this cycle

  // safety outputs force off unless software disabled that
  assign forced_off = !r.fs_dis && (reset_output || safety_output_0 || limp_home_output);
  // nonzero mode or wake enable keeps the transceiver wake-capable
  assign want_wake = (r.mode != lin_mode_pkg::MODE_OFF) || r.wake_en;
  // mode 1x with tx recessive, and no pending fault lockout
  assign go_active = r.mode[1] && tx_in_pin && !r.tx_block && !thermal_shutdown;
  // mode 01, or mode 1x with tx dominant
  assign go_listen = (r.mode == lin_mode_pkg::MODE_LISTEN) || (r.mode[1] && !tx_in_pin);
  // any fault that causes a fall back from active
  assign fault_hit = thermal_shutdown || dom_to_done || short_done;
  // only nonseq or seq transfers with the bus ready are taken
  assign addr_valid = hsel && htrans[1] && hready;
  // long low followed by a rising edge
  assign wake_hit = r.armed && lp_rise && (r.state == lin_mode_pkg::ST_WAKE);

  ////////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb begin
    n = r;
    n.wake_pulse = 1'b0;

    // transceiver state selection, one of four states only
    if (forced_off || !want_wake) begin
      // safety shutdown or nothing enabled
      n.state = lin_mode_pkg::ST_OFF;
    end else if (!device_normal) begin
      // low power keeps only wake capability
      n.state = lin_mode_pkg::ST_WAKE;
    end else begin
      case (r.state)
        lin_mode_pkg::ST_OFF: begin
          // powering up always passes through wake-capable
          n.state = lin_mode_pkg::ST_WAKE;
        end
        lin_mode_pkg::ST_WAKE: begin
          if (go_active) begin
            n.state = lin_mode_pkg::ST_ACTIVE;
          end else if (go_listen || r.mode[1]) begin
            n.state = lin_mode_pkg::ST_LISTEN;
          end
        end
        lin_mode_pkg::ST_LISTEN: begin
          if (r.mode == lin_mode_pkg::MODE_OFF) begin
            // wake enable alone, drop back to wake-capable
            n.state = lin_mode_pkg::ST_WAKE;
          end else if (go_active) begin
            n.state = lin_mode_pkg::ST_ACTIVE;
          end
        end
        lin_mode_pkg::ST_ACTIVE: begin
          if (r.mode == lin_mode_pkg::MODE_OFF) begin
            n.state = lin_mode_pkg::ST_WAKE;
          end else if (fault_hit || r.mode == lin_mode_pkg::MODE_LISTEN) begin
            // fall back and stop transmitting
            n.state = lin_mode_pkg::ST_LISTEN;
          end
        end
        default: begin
          n.state = lin_mode_pkg::ST_OFF;
        end
      endcase
    end

    // transmitter lockout after timeout or short, released by tx rising edge
    if (r.state == lin_mode_pkg::ST_ACTIVE && (dom_to_done || short_done)) begin
      n.tx_block = 1'b1;
    end else if (tx_rise || n.state == lin_mode_pkg::ST_OFF) begin
      n.tx_block = 1'b0;
    end

    // wake qualification: arm on a long low, fire on the release
    if (r.state != lin_mode_pkg::ST_WAKE || wake_hit) begin
      n.armed = 1'b0;
    end else if (wake_low_done) begin
      n.armed = 1'b1;
    end
    n.wake_pulse = wake_hit;

    // ahb data phase: register writes
    if (r.wr_pend) begin
      case (r.waddr)
        lin_mode_pkg::ADDR_CTRL: begin
          n.mode = hwdata[lin_mode_pkg::CTRL_MODE_LSB +: 2];
          n.wake_en = hwdata[lin_mode_pkg::CTRL_WAKE_EN_BIT];
          n.fs_dis = hwdata[lin_mode_pkg::CTRL_FS_DIS_BIT];
          n.slope = hwdata[lin_mode_pkg::CTRL_SLOPE_LSB +: 2];
        end
        lin_mode_pkg::ADDR_FLAGS: begin
          // write one to clear
          n.flags = r.flags & ~hwdata[3:0];
        end
        default: begin
          // status and unmapped writes are ignored
          n.flags = r.flags;
        end
      endcase
    end

    // event capture after the clear, so a new event is never lost
    if (wake_hit) begin
      n.flags[lin_mode_pkg::FLAG_WAKE_BIT] = 1'b1;
    end
    if (r.state == lin_mode_pkg::ST_ACTIVE && dom_to_done) begin
      n.flags[lin_mode_pkg::FLAG_DOM_TO_BIT] = 1'b1;
    end
    if (r.state == lin_mode_pkg::ST_ACTIVE && short_done) begin
      n.flags[lin_mode_pkg::FLAG_SHORT_BIT] = 1'b1;
    end
    if (r.state == lin_mode_pkg::ST_ACTIVE && thermal_shutdown) begin
      n.flags[lin_mode_pkg::FLAG_THERMAL_BIT] = 1'b1;
    end

    // ahb address phase: latch writes, fetch read data
    n.wr_pend = addr_valid && hwrite;
    n.waddr = haddr[7:0];
    n.rdata = 32'h0000_0000;
    if (addr_valid && !hwrite) begin
      case (haddr[7:0])
        lin_mode_pkg::ADDR_CTRL: begin
          n.rdata[lin_mode_pkg::CTRL_MODE_LSB +: 2] = r.mode;
          n.rdata[lin_mode_pkg::CTRL_WAKE_EN_BIT] = r.wake_en;
          n.rdata[lin_mode_pkg::CTRL_FS_DIS_BIT] = r.fs_dis;
          n.rdata[lin_mode_pkg::CTRL_SLOPE_LSB +: 2] = r.slope;
        end
        lin_mode_pkg::ADDR_STATUS: begin
          n.rdata[lin_mode_pkg::STAT_STATE_LSB +: 4] = r.state;
          n.rdata[lin_mode_pkg::STAT_TX_EN_BIT] = r.tx_en;
          n.rdata[lin_mode_pkg::STAT_TX_BLOCK_BIT] = r.tx_block;
          n.rdata[lin_mode_pkg::STAT_FORCED_BIT] = forced_off;
        end
        lin_mode_pkg::ADDR_FLAGS: begin
          n.rdata[3:0] = r.flags;
        end
        default: begin
          // unmapped reads return zero
          n.rdata = 32'h0000_0000;
        end
      endcase
    end

    // front-end controls follow the next state
    case (n.state)
      lin_mode_pkg::ST_OFF: begin
        // everything off, receive pin high
        n.tx_en = 1'b0;
        n.nrx_en = 1'b0;
        n.lprx_en = 1'b0;
        n.rx_out = 1'b1;
      end
      lin_mode_pkg::ST_WAKE: begin
        // only the wake receiver listens
        n.tx_en = 1'b0;
        n.nrx_en = 1'b0;
        n.lprx_en = 1'b1;
        n.rx_out = 1'b1;
      end
      lin_mode_pkg::ST_LISTEN: begin
        // receive only, tx is never passed on
        n.tx_en = 1'b0;
        n.nrx_en = 1'b1;
        n.lprx_en = 1'b0;
        n.rx_out = bus_rx_level;
      end
      lin_mode_pkg::ST_ACTIVE: begin
        // full transceiver
        n.tx_en = 1'b1;
        n.nrx_en = 1'b1;
        n.lprx_en = 1'b0;
        n.rx_out = bus_rx_level;
      end
      default: begin
        n.tx_en = 1'b0;
        n.nrx_en = 1'b0;
        n.lprx_en = 1'b0;
        n.rx_out = 1'b1;
      end
    endcase
    // bus driver follows tx only while transmitting, recessive otherwise
    n.tx_lvl = n.tx_en ? tx_in_pin : 1'b1;
    // reduced emission slope only in active
    n.slope_lo = n.tx_en && (r.slope == lin_mode_pkg::SLOPE_REDUCED);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= CTL_RESET;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  // zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = r.rdata;

  // pins and front end
  assign rx_out_pin = r.rx_out;
  assign tx_driver_en = r.tx_en;
  assign bus_tx_level = r.tx_lvl;
  assign normal_rx_en = r.nrx_en;
  assign lp_rx_en = r.lprx_en;
  assign slope_reduced = r.slope_lo;
  assign wake_event = r.wake_pulse;

endmodule

// file: verification/lin_host_model.sv
// host lin controller model that drives the transmit pin
`timescale 1ns/1ns
module lin_host_model #(
  parameter int SETUP_CYCLES = 1000  // 50 us at 20 mhz before sending
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // commands from the bench
  input wire logic hold_dom,
  input wire logic send,
  // transceiver state seen by the host
  input wire logic tx_driver_en,
  // transmit pin
  output logic tx_in_pin
);
  int wait_cnt;  // cycles since the transmitter came on
  logic [2:0] bit_cnt;  // phase of the send pattern
  // recessive unless holding dominant or sending after setup
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_cnt <= 0;
      bit_cnt <= 3'h0;
      tx_in_pin <= 1'b1;
    end else begin
      // setup time restarts whenever the transmitter drops
      wait_cnt <= !tx_driver_en ? 0 : (wait_cnt < SETUP_CYCLES ? wait_cnt + 1 : wait_cnt);
      bit_cnt <= bit_cnt + 3'h1;
      // ending a hold gives the rising edge that re-arms the driver
      tx_in_pin <= !hold_dom && !(send && wait_cnt == SETUP_CYCLES && bit_cnt[2]);
    end
  end
endmodule

// file: verification/lin_mode_chk.sv
// port assertions of the lin transceiver mode controller
`timescale 1ns/1ns
module lin_mode_chk (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // watched inputs
  input wire logic device_normal,
  input wire logic thermal_shutdown,
  input wire logic tx_in_pin,
  input wire logic bus_rx_level,
  // watched outputs
  input wire logic rx_out_pin,
  input wire logic tx_driver_en,
  input wire logic bus_tx_level,
  input wire logic normal_rx_en,
  input wire logic lp_rx_en,
  input wire logic slope_reduced,
  input wire logic wake_event
);
  // one domain for every property
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_quiet_rx_high: assert property (!normal_rx_en |-> rx_out_pin)
    else $error("rx pin low with normal receiver off");
  a_rx_tracks: assert property (normal_rx_en |-> rx_out_pin == $past(bus_rx_level))
    else $error("rx pin does not follow bus level");
  a_tx_follows_pin: assert property (tx_driver_en |-> bus_tx_level == $past(tx_in_pin))
    else $error("bus drive does not follow tx pin");
  a_idle_recessive: assert property (!tx_driver_en |-> bus_tx_level)
    else $error("bus driven dominant with transmitter off");
  a_rx_exclusive: assert property (!(normal_rx_en && lp_rx_en))
    else $error("both receivers enabled");
  a_active_setup: assert property (tx_driver_en |-> normal_rx_en && !lp_rx_en)
    else $error("transmitter on without normal receiver only");
  a_low_power_quiet: assert property (!device_normal |=> !normal_rx_en && !tx_driver_en)
    else $error("listen or active outside normal power");
  a_thermal_drop: assert property (thermal_shutdown |=> !tx_driver_en)
    else $error("transmitter on during thermal shutdown");
  a_slope_active: assert property (slope_reduced |-> tx_driver_en)
    else $error("reduced slope outside active");
  a_wake_single: assert property (wake_event |=> !wake_event)
    else $error("wake event longer than one cycle");
endmodule

bind lin_transceiver_mode_control lin_mode_chk chk_u (.hclk, .hresetn, .device_normal,
  .thermal_shutdown, .tx_in_pin, .bus_rx_level, .rx_out_pin, .tx_driver_en, .bus_tx_level,
  .normal_rx_en, .lp_rx_en, .slope_reduced, .wake_event);

// file: verification/tb_top.sv
// self-checking bench of the lin transceiver mode controller
`timescale 1ns/1ns
`define CHK(n, e, s) begin compares++; if ((e) !== (s)) begin error_cnt++; \
  $display("CHECK FAILED %s exp %h seen %h", n, e, s); end end
module tb_top;
  localparam int DOM = 20;  // shortened dominant timeout
  localparam logic [7:0] CT = lin_mode_pkg::ADDR_CTRL;
  localparam logic [7:0] ST = lin_mode_pkg::ADDR_STATUS;
  localparam logic [7:0] FL = lin_mode_pkg::ADDR_FLAGS;
  // bench driven inputs
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hold_dom = 0, send = 0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic device_normal = 1, reset_output = 0, safety_output_0 = 0, limp_home_output = 0;
  logic thermal_shutdown = 0, bus_rx_level = 1, lp_rx_level = 1, bus_short_fault = 0;
  logic [7:0] rnd = 8'h29;  // lfsr seeded with 41
  // design outputs
  logic tx_in_pin, hreadyout, hresp, rx_out_pin, tx_driver_en, bus_tx_level;
  logic normal_rx_en, lp_rx_en, slope_reduced, wake_event;
  logic [31:0] hrdata;
  // reference model state
  int m_st = 1, m_dc, m_sc, m_lc, error_cnt = 0, compares = 0, cyc = 0, wk_seen = 0;
  logic [5:0] m_ctrl = 6'h0;
  logic [3:0] m_fl;
  logic m_wp, m_slo, m_lock, m_txp, m_lpp, m_rx, m_btx, fo;
  always #25 hclk = ~hclk;
  lin_transceiver_mode_control #(.DOM_TIMEOUT_CYCLES(DOM)) dut_u (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .device_normal(device_normal), .reset_output(reset_output),
    .safety_output_0(safety_output_0), .limp_home_output(limp_home_output),
    .thermal_shutdown(thermal_shutdown), .tx_in_pin(tx_in_pin), .rx_out_pin(rx_out_pin),
    .bus_rx_level(bus_rx_level), .lp_rx_level(lp_rx_level), .bus_short_fault(bus_short_fault),
    .tx_driver_en(tx_driver_en), .bus_tx_level(bus_tx_level), .normal_rx_en(normal_rx_en),
    .lp_rx_en(lp_rx_en), .slope_reduced(slope_reduced), .wake_event(wake_event));
  lin_host_model host_u (.hclk(hclk), .hresetn(hresetn), .hold_dom(hold_dom), .send(send),
    .tx_driver_en(tx_driver_en), .tx_in_pin(tx_in_pin));
  assign fo = (reset_output | safety_output_0 | limp_home_output) & !m_ctrl[3];
  ////////////////////////////////////////////////////////////////////////////////
  // reference model: state 1 off, 2 wake, 4 listen, 8 active
  always @(posedge hclk or negedge hresetn) begin
    int nx;
    logic to, sc, act;
    if (!hresetn) begin
      {m_wp, m_slo, m_lock, m_txp, m_lpp, m_rx, m_btx, m_fl} <= 11'h0f0;
      {m_st, m_dc, m_sc, m_lc} <= {32'd1, 96'd0};
    end else begin
      to = m_st == 8 && !tx_in_pin && m_dc == DOM;
      sc = m_st == 8 && bus_short_fault && m_sc == 500;
      act = m_ctrl[1] && tx_in_pin && !m_lock && !thermal_shutdown;
      if (fo || (m_ctrl[1:0] == 2'h0 && !m_ctrl[2])) nx = 1;
      else if (!device_normal || m_st == 1 || m_ctrl[1:0] == 2'h0) nx = 2;
      else if (m_st == 8) nx = (m_ctrl[1:0] == 2'h1 || thermal_shutdown || to || sc) ? 4 : 8;
      else nx = act ? 8 : 4;
      m_dc <= (m_st == 8 && !tx_in_pin) ? m_dc + 1 : 0;
      m_sc <= (m_st == 8 && bus_short_fault) ? m_sc + 1 : 0;
      m_lc <= (m_st == 2 && !lp_rx_level) ? m_lc + 1 : 0;
      // lockout cleared by a tx rising edge or by going off
      if (to || sc) m_lock <= 1'b1;
      else if (nx == 1 || (tx_in_pin && !m_txp)) m_lock <= 1'b0;
      m_fl <= m_fl & ~(m_wp ? hwdata[3:0] : 4'h0) | {thermal_shutdown && m_st == 8, sc, to,
        m_st == 2 && lp_rx_level && !m_lpp && m_lc >= 1600};
      m_txp <= tx_in_pin;
      m_lpp <= lp_rx_level;
      m_st <= nx;
      m_rx <= nx >= 4 ? bus_rx_level : 1'b1;
      m_btx <= nx == 8 ? tx_in_pin : 1'b1;
      m_slo <= nx == 8 && m_ctrl[5:4] == 2'h2;
      m_wp <= hsel & htrans[1] & hwrite & haddr[7:0] == FL;
    end
  end
  // front-end pins against the model every cycle
  always @(negedge hclk) begin
    `CHK("pins", {m_st == 8, m_st >= 4, m_st == 2, m_rx, m_btx, m_slo}, {tx_driver_en,
      normal_rx_en, lp_rx_en, rx_out_pin, bus_tx_level, slope_reduced})
  end
  // lfsr step
  function automatic logic [7:0] lfsr(logic [7:0] v);
    return {v[6:0], ^(v & 8'hb8)};
  endfunction
  // random bus level, wake pulse count and run limit
  always @(posedge hclk) begin
    rnd <= lfsr(rnd);
    bus_rx_level <= rnd[0];
    wk_seen += wake_event;
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // ahb-lite single word transfer
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge hclk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  // write and mirror into the model
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
    if (a == CT) m_ctrl <= d[5:0];
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, rd);
    `CHK("read", {1'b0, e}, {hresp, rd})
  endtask
  // status and flags against the model
  task automatic st_chk;
    rd_chk(ST, {25'h0, fo, m_lock, m_st == 8, m_st[3:0]});
    rd_chk(FL, {28'h0, m_fl});
  endtask
  task automatic run(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic test_done;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    run(10);
    hresetn <= 1'b1;
    rd_chk(CT, 32'h0);
    rd_chk(8'h0c, 32'h0);
    for (int i = 0; i < 8; i++) begin
      wr(CT, i);
      run(4);
      st_chk();
    end
    wr(ST, 32'hff);
    st_chk();
    send <= 1'b1;
    run(1200);
    for (int s = 0; s < 4; s++) begin
      wr(CT, {s[1:0], 4'h2});
      run(200);
    end
    {send, hold_dom} <= 2'b01;
    wr(CT, 32'h0);
    wr(CT, 32'h2);
    run(4);
    st_chk();
    hold_dom <= 1'b0;
    run(4);
    st_chk();
    hold_dom <= 1'b1;
    run(DOM + 5);
    st_chk();
    hold_dom <= 1'b0;
    run(4);
    st_chk();
    wr(FL, 32'hf);
    bus_short_fault <= 1'b1;
    run(510);
    bus_short_fault <= 1'b0;
    run(4);
    st_chk();
    hold_dom <= 1'b1;
    run(2);
    hold_dom <= 1'b0;
    run(4);
    st_chk();
    thermal_shutdown <= 1'b1;
    run(3);
    st_chk();
    thermal_shutdown <= 1'b0;
    run(3);
    st_chk();
    for (int i = 0; i < 4; i++) begin
      {reset_output, safety_output_0, limp_home_output} <= 3'h1 << i;
      run(3);
      st_chk();
      if (i == 2) wr(CT, 32'ha);
    end
    run(3);
    st_chk();
    device_normal <= 1'b0;
    run(3);
    st_chk();
    for (int n = 0; n < 2; n++) begin
      lp_rx_level <= 1'b0;
      run(n == 0 ? 1700 : 300);
      lp_rx_level <= 1'b1;
      run(5);
    end
    `CHK("wakes", 1, wk_seen)
    st_chk();
    wr(CT, 32'h0);
    run(3);
    st_chk();
    device_normal <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      wr(CT, rnd[5:0]);
      run(8);
      st_chk();
    end
    test_done();
  end
endmodule
